//--- inc/sudc_pkg.sv
/*
  Constants shared by both ends of the up/down counter: widths, limits,
  timing figures, controller register map and controller states.
  Assumes a 100 MHz system clock shared by both ends.
*/
package sudc_pkg;

  // counter width and limits
  localparam int         CNT_W    = 4;
  localparam logic [3:0] BIN_MAX  = 4'hf;
  localparam logic [3:0] DEC_MAX  = 4'h9;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE  = 4'h1;

  // timing, in ns, and derived cycle counts (least times round up)
  localparam int CLK_PERIOD_NS    = 10;
  localparam int CLK_HALF_MIN_NS  = 25;
  localparam int CLK_HALF_MIN_CYC = (CLK_HALF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_MIN_NS      = 35;
  localparam int LOAD_CYC         = (LOAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // controller command port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DIV_W  = 16;
  localparam int EV_W   = 2;

  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] DIV_OFS    = 8'h04;
  localparam logic [7:0] PRESET_OFS = 8'h08;
  localparam logic [7:0] COUNT_OFS  = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] MASK_OFS   = 8'h14;

  // field positions
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_DOWN_BIT  = 1;
  localparam int CTRL_LOAD_BIT  = 2;
  localparam int CNT_TC_BIT     = 4;
  localparam int CNT_RIPPLE_BIT = 5;
  localparam int CNT_BUSY_BIT   = 6;
  localparam int EV_WRAP_BIT    = 0;
  localparam int EV_LOAD_BIT    = 1;

  // reset values
  localparam logic [15:0] DIV_RESET    = 16'h0005;
  localparam logic [3:0]  PRESET_RESET = 4'h0;

  // controller load sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_LOAD = 3'b100
  } sudc_ctl_state_t;

endpackage : sudc_pkg

//--- inc/sudc_if.sv
/*
  Pin bundle between the counter and its controlling logic.
  Assumes both ends run from the same system clock; the counting clock
  is an ordinary signal produced by the controller.
*/
`timescale 1ns/1ps
interface sudc_if;

  // controller to counter
  logic       cnt_clk;
  logic       cnt_en_n;
  logic       cnt_down;
  logic       load_n;
  logic [3:0] preset;

  // counter to controller
  logic [3:0] q;
  logic       max_min;
  logic       ripple_n;

  modport dev (
    input  cnt_clk,
    input  cnt_en_n,
    input  cnt_down,
    input  load_n,
    input  preset,
    output q,
    output max_min,
    output ripple_n
  );

  modport ctl (
    output cnt_clk,
    output cnt_en_n,
    output cnt_down,
    output load_n,
    output preset,
    input  q,
    input  max_min,
    input  ripple_n
  );

endinterface : sudc_if

//--- hw/sudc_counter.sv
/*
  Four-bit synchronous up/down counter, binary or decimal by parameter,
  with preset load, terminal-count and ripple strobe outputs.
  Assumes the pin bundle is driven by logic on the same system clock;
  the counting clock arrives as a level and is edge-detected here.
*/
`timescale 1ns/1ps
module sudc_counter #(
  parameter bit DECIMAL = 1'b0
) (
  // system
  input  wire logic        clock,
  input  wire logic        rst,
  // pins toward the controller
  sudc_if.dev              pins,
  // cascade toward a further stage
  output      logic        cascade_ripple_n,
  output      logic        cascade_max_min,
  output      logic [3:0]  count_q
);

  // count limit fixed by the variant
  localparam logic [3:0] TOP = DECIMAL ? sudc_pkg::DEC_MAX : sudc_pkg::BIN_MAX;

  // next value in either direction with wrap at the limits
  function automatic logic [3:0] sudc_step(
    input logic [3:0] v,
    input logic       down,
    input logic [3:0] top
  );
    logic [3:0] r;
    r = v;
    if (down) begin
      if (v == sudc_pkg::CNT_ZERO) begin
        r = top;
      end else if (v > top) begin
        r = top;
      end else begin
        r = v - sudc_pkg::CNT_ONE;
      end
    end else begin
      if (v >= top) begin
        r = sudc_pkg::CNT_ZERO;
      end else begin
        r = v + sudc_pkg::CNT_ONE;
      end
    end
    sudc_step = r;
  endfunction : sudc_step

  // limit decode in the present direction
  function automatic logic sudc_at_limit(
    input logic [3:0] v,
    input logic       down,
    input logic [3:0] top
  );
    logic r;
    r = 1'b0;
    if (down) begin
      r = (v == sudc_pkg::CNT_ZERO);
    end else begin
      r = (v == top);
    end
    sudc_at_limit = r;
  endfunction : sudc_at_limit

  logic       clk_prev_reg;
  logic       clk_rise;
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic [3:0] q_view;
  logic       at_limit;
  logic       tc;
  logic       ripple_low;

  // previous level of the counting clock; idles high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clk_prev_reg <= 1'b1;
    end else begin
      clk_prev_reg <= pins.cnt_clk;
    end
  end

  // a rising edge is seen in the first cycle the level reads high
  assign clk_rise = pins.cnt_clk & ~clk_prev_reg;

  // next count: step only on an enabled edge, else keep
  always_comb begin
    count_next = count_reg;
    if (clk_rise && !pins.cnt_en_n) begin
      count_next = sudc_step(count_reg, pins.cnt_down, TOP);
    end else begin
      count_next = count_reg;
    end
  end

  // all four bits share one flip-flop group on one clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg <= sudc_pkg::CNT_ZERO;
    end else if (!pins.load_n) begin
      count_reg <= pins.preset;
    end else begin
      count_reg <= count_next;
    end
  end

  // load bypass so the outputs follow data in the same cycle,
  // not one system clock later; costs a mux on the output path
  always_comb begin
    if (!pins.load_n) begin
      q_view = pins.preset;
    end else begin
      q_view = count_reg;
    end
  end

  // limit with counting enabled marks overflow or underflow
  assign at_limit = sudc_at_limit(q_view, pins.cnt_down, TOP);
  assign tc       = at_limit & ~pins.cnt_en_n;

  // terminal count stands from the edge reaching the limit to the
  // edge leaving it, which is one counting clock period
  assign pins.max_min = tc;

  // ripple strobe follows the low phase of the counting clock;
  // masked during load so a preset never fires a false carry
  assign ripple_low    = tc & ~pins.cnt_clk & pins.load_n;
  assign pins.ripple_n = ~ripple_low;

  // parallel outputs
  assign pins.q = q_view;

  // cascade copies for the next stage's enable or clock
  assign cascade_ripple_n = ~ripple_low;
  assign cascade_max_min  = tc;
  assign count_q          = q_view;

endmodule : sudc_counter

//--- hw/sudc_ctl.sv
/*
  Controlling logic for the up/down counter: command registers, counting
  clock divider, enable and direction timing, load pulse and interrupts.
  Assumes a plain command port on the system clock and the counter end
  joined through the pin bundle on the same clock.
*/
// Overview of operation
// - count only on rising edges while enabled
// - enable high holds the count
// - enable changes only during clock high
// - direction low counts up, high down
// - direction never changes while clock low
// - avoid clock, enable low, down during load
// - load low forces outputs to data
// - binary or eight-four-two-one decimal code
// - decimal wraps nine to zero and back
// - binary wraps fifteen to zero and back
// - terminal count high about one period
// - ripple strobe low during clock low
// - cascade ripple into enable or clock
// - one common clock for all flip-flops
`timescale 1ns/1ps
module sudc_ctl #(
  parameter int LOAD_CYCLES = sudc_pkg::LOAD_CYC
) (
  // system
  input  wire logic                        clock,
  input  wire logic                        rst,
  // command port
  input  wire logic [sudc_pkg::ADDR_W-1:0] addr,
  input  wire logic [sudc_pkg::DATA_W-1:0] wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output      logic [sudc_pkg::DATA_W-1:0] rdata,
  // interrupt
  output      logic                        irq,
  // pins toward the counter
  sudc_if.ctl                              pins
);

  localparam logic [15:0] HALF_MIN = 16'(sudc_pkg::CLK_HALF_MIN_CYC);
  localparam logic [7:0]  LOAD_END = 8'(LOAD_CYCLES - 1);

  logic                          run_reg;
  logic                          down_reg;
  logic                          load_req_reg;
  logic [15:0]                   div_reg;
  logic [3:0]                    preset_reg;
  logic [sudc_pkg::EV_W-1:0]     status_reg;
  logic [sudc_pkg::EV_W-1:0]     mask_reg;
  logic [sudc_pkg::EV_W-1:0]     events;
  logic [sudc_pkg::DATA_W-1:0]   rdata_reg;
  logic [15:0]                   half_cnt_reg;
  logic [15:0]                   half_len;
  logic                          tick;
  logic                          cclk_reg;
  logic                          en_n_reg;
  logic                          down_pin_reg;
  logic                          load_n_reg;
  logic [7:0]                    load_cnt_reg;
  logic                          ripple_prev_reg;
  logic                          high_safe;
  sudc_pkg::sudc_ctl_state_t     state_reg;

  // register writes; a load command is a one-shot request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      run_reg      <= 1'b0;
      down_reg     <= 1'b0;
      load_req_reg <= 1'b0;
      div_reg      <= sudc_pkg::DIV_RESET;
      preset_reg   <= sudc_pkg::PRESET_RESET;
      mask_reg     <= '0;
    end else begin
      if (state_reg == sudc_pkg::ST_WAIT) begin
        load_req_reg <= 1'b0;
      end
      if (wr) begin
        if (addr == sudc_pkg::CTRL_OFS) begin
          run_reg  <= wdata[sudc_pkg::CTRL_RUN_BIT];
          down_reg <= wdata[sudc_pkg::CTRL_DOWN_BIT];
          if (wdata[sudc_pkg::CTRL_LOAD_BIT]) begin
            load_req_reg <= 1'b1;
          end
        end else if (addr == sudc_pkg::DIV_OFS) begin
          div_reg <= wdata[15:0];
        end else if (addr == sudc_pkg::PRESET_OFS) begin
          preset_reg <= wdata[3:0];
        end else if (addr == sudc_pkg::MASK_OFS) begin
          mask_reg <= wdata[sudc_pkg::EV_W-1:0];
        end
      end
    end
  end

  // half period never below the least clock width
  assign half_len = (div_reg < HALF_MIN) ? HALF_MIN : div_reg;
  assign tick     = (half_cnt_reg == 16'h0000);

  // counting clock divider, free running, idles high from reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      half_cnt_reg <= 16'h0000;
      cclk_reg     <= 1'b1;
    end else if (tick) begin
      half_cnt_reg <= half_len - 16'h0001;
      cclk_reg     <= ~cclk_reg;
    end else begin
      half_cnt_reg <= half_cnt_reg - 16'h0001;
    end
  end

  // safe to move enable or direction: clock high and not about to fall
  assign high_safe = cclk_reg & ~tick;

  // load sequencer: wait for clock high, disable, pulse load
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg    <= sudc_pkg::ST_IDLE;
      load_n_reg   <= 1'b1;
      load_cnt_reg <= 8'h00;
    end else begin
      case (state_reg)
        sudc_pkg::ST_IDLE: begin
          if (load_req_reg) begin
            state_reg <= sudc_pkg::ST_WAIT;
          end
        end
        sudc_pkg::ST_WAIT: begin
          if (high_safe) begin
            state_reg    <= sudc_pkg::ST_LOAD;
            load_n_reg   <= 1'b0;
            load_cnt_reg <= 8'h00;
          end
        end
        sudc_pkg::ST_LOAD: begin
          if (load_cnt_reg == LOAD_END) begin
            state_reg  <= sudc_pkg::ST_IDLE;
            load_n_reg <= 1'b1;
          end else begin
            load_cnt_reg <= load_cnt_reg + 8'h01;
          end
        end
        default: begin
          state_reg <= sudc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // enable and direction move only in the clock high phase;
  // enable is forced off for the whole load pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      en_n_reg     <= 1'b1;
      down_pin_reg <= 1'b0;
    end else if (high_safe) begin
      if (state_reg == sudc_pkg::ST_IDLE && !load_req_reg) begin
        en_n_reg     <= ~run_reg;
        down_pin_reg <= down_reg;
      end else begin
        en_n_reg <= 1'b1;
      end
    end
  end

  // event capture: ripple fall and load completion
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ripple_prev_reg <= 1'b1;
    end else begin
      ripple_prev_reg <= pins.ripple_n;
    end
  end

  always_comb begin
    events = '0;
    events[sudc_pkg::EV_WRAP_BIT] = ripple_prev_reg & ~pins.ripple_n;
    events[sudc_pkg::EV_LOAD_BIT] = (state_reg == sudc_pkg::ST_LOAD) &&
                                    (load_cnt_reg == LOAD_END);
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_reg <= '0;
    end else if (wr && addr == sudc_pkg::STATUS_OFS) begin
      status_reg <= (status_reg & ~wdata[sudc_pkg::EV_W-1:0]) | events;
    end else begin
      status_reg <= status_reg | events;
    end
  end

  assign irq = |(status_reg & mask_reg);

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= '0;
      if (rd) begin
        if (addr == sudc_pkg::CTRL_OFS) begin
          rdata_reg[sudc_pkg::CTRL_RUN_BIT]  <= run_reg;
          rdata_reg[sudc_pkg::CTRL_DOWN_BIT] <= down_reg;
          rdata_reg[sudc_pkg::CTRL_LOAD_BIT] <= load_req_reg;
        end else if (addr == sudc_pkg::DIV_OFS) begin
          rdata_reg[15:0] <= div_reg;
        end else if (addr == sudc_pkg::PRESET_OFS) begin
          rdata_reg[3:0] <= preset_reg;
        end else if (addr == sudc_pkg::COUNT_OFS) begin
          rdata_reg[3:0]                      <= pins.q;
          rdata_reg[sudc_pkg::CNT_TC_BIT]     <= pins.max_min;
          rdata_reg[sudc_pkg::CNT_RIPPLE_BIT] <= pins.ripple_n;
          rdata_reg[sudc_pkg::CNT_BUSY_BIT]   <= (state_reg != sudc_pkg::ST_IDLE);
        end else if (addr == sudc_pkg::STATUS_OFS) begin
          rdata_reg[sudc_pkg::EV_W-1:0] <= status_reg;
        end else if (addr == sudc_pkg::MASK_OFS) begin
          rdata_reg[sudc_pkg::EV_W-1:0] <= mask_reg;
        end
      end
    end
  end

  assign rdata         = rdata_reg;
  assign pins.cnt_clk  = cclk_reg;
  assign pins.cnt_en_n = en_n_reg;
  assign pins.cnt_down = down_pin_reg;
  assign pins.load_n   = load_n_reg;
  assign pins.preset   = preset_reg;

endmodule : sudc_ctl

//--- tb/sudc_pins_sva.sv
/*
  Checker on the pin bundle between controller and counter.
  Assumes one decimal pair and a load pulse of four system cycles.
*/
`timescale 1ns/1ps
module sudc_pins_sva #(
  parameter bit DECIMAL = 1'b1
) (
  // system
  input wire logic       clock,
  input wire logic       rst,
  // pins
  input wire logic       cnt_clk,
  input wire logic       cnt_en_n,
  input wire logic       cnt_down,
  input wire logic       load_n,
  input wire logic [3:0] preset,
  input wire logic [3:0] q,
  input wire logic       max_min,
  input wire logic       ripple_n
);
  // limit of the chosen code; codes above it step to zero counting up and to the limit counting down
  logic [3:0] top;
  logic       lim;
  assign top = DECIMAL ? sudc_pkg::DEC_MAX : sudc_pkg::BIN_MAX;
  assign lim = cnt_down ? (q == 4'h0) : (q == top);

  function automatic logic [3:0] step_val(input logic [3:0] v, input logic dn);
    if (dn) return (v == 4'h0 || v > top) ? top : v - 4'h1;
    return (v >= top) ? 4'h0 : v + 4'h1;
  endfunction : step_val

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  property p_load; !load_n |-> q == preset; endproperty
  a_load: assert property (p_load) else $error("q not preset in load");
  property p_load_len; $fell(load_n) |-> !load_n[*4] ##1 load_n; endproperty
  a_load_len: assert property (p_load_len) else $error("load width");
  property p_count;
    $rose(cnt_clk) && !cnt_en_n && load_n |=>
      !load_n || q == step_val($past(q), $past(cnt_down));
  endproperty
  a_count: assert property (p_count) else $error("bad count step");
  property p_hold;
    load_n && !($rose(cnt_clk) && !cnt_en_n) |=> !load_n || $stable(q);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved");
  property p_mm; max_min == (!cnt_en_n && lim); endproperty
  a_mm: assert property (p_mm) else $error("terminal count");
  property p_rip; ripple_n == !(max_min && !cnt_clk && load_n); endproperty
  a_rip: assert property (p_rip) else $error("ripple strobe");
  property p_en; !$stable(cnt_en_n) |-> cnt_clk && $past(cnt_clk); endproperty
  a_en: assert property (p_en) else $error("enable moved in low phase");
  property p_dir; !$stable(cnt_down) |-> cnt_clk && $past(cnt_clk); endproperty
  a_dir: assert property (p_dir) else $error("direction moved in low phase");
  property p_safe; !load_n |-> !(!cnt_clk && !cnt_en_n && cnt_down); endproperty
  a_safe: assert property (p_safe) else $error("unsafe load");
endmodule : sudc_pins_sva

//--- tb/sync_updown_counter_bcd_bin_test.sv
/*
  Bench: a binary and a decimal pair share one command port; a model
  follows the counting pins and is compared at every edge and read.
  Assumes the controller's own register map and one system clock.
*/
`timescale 1ns/1ps
module sync_updown_counter_bcd_bin_test;
  logic        clock;
  logic        rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata [2];
  logic        irq [2];
  logic [31:0] got [2];
  logic [1:0]  mask;
  logic [3:0]  p;
  logic [3:0]  tbl [4] = '{4'h7, 4'hd, 4'h9, 4'h0};
  int          k;
  int          n_fail;
  int          checks;
  int          exp_q [2];
  logic [1:0]  exp_st [2];

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    got[0] = rdata[0];
    got[1] = rdata[1];
  endtask : rd_reg

  task automatic print_verdict();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  for (genvar g = 0; g < 2; g++) begin : g_pair
    localparam int TOP = g ? int'(sudc_pkg::DEC_MAX) : int'(sudc_pkg::BIN_MAX);
    logic clk_d;
    logic ld_d;
    logic [3:0] cq;
    logic cmm;
    logic crn;
    logic mm;
    sudc_if pins ();
    sudc_ctl u_sudc_ctl (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata[g]), .irq(irq[g]), .pins(pins));
    sudc_counter #(.DECIMAL(g == 1)) u_sudc_counter (.clock(clock), .rst(rst), .pins(pins),
      .cascade_ripple_n(crn), .cascade_max_min(cmm), .count_q(cq));
    // model sees sampled pins, so it compares before it steps
    always @(posedge clock or posedge rst) begin
      if (rst) begin
        exp_q[g] = 0;
        exp_st[g] = 2'h0;
        clk_d = 1'b1;
        ld_d = 1'b1;
      end else begin
        if (pins.load_n) begin
          mm = !pins.cnt_en_n && (pins.cnt_down ? exp_q[g] == 0 : exp_q[g] == TOP);
          check(32'(pins.q), 32'(exp_q[g]));
          check(32'(cq), 32'(exp_q[g]));
          check(32'(cmm), 32'(mm));
          check(32'(crn), 32'(!(mm && !pins.cnt_clk)));
        end else begin
          check(32'(cq), 32'(pins.preset));
        end
        if (wr && addr == sudc_pkg::STATUS_OFS) exp_st[g] = exp_st[g] & ~wdata[1:0];
        if (pins.load_n && !ld_d) exp_st[g][1] = 1'b1;
        if (!pins.load_n) exp_q[g] = 32'(pins.preset);
        else if (pins.cnt_clk && !clk_d && !pins.cnt_en_n) begin
          if (pins.cnt_down ? exp_q[g] == 0 : exp_q[g] == TOP) exp_st[g][0] = 1'b1;
          if (pins.cnt_down) exp_q[g] = (exp_q[g] == 0 || exp_q[g] > TOP) ? TOP : exp_q[g] - 1;
          else exp_q[g] = (exp_q[g] >= TOP) ? 0 : exp_q[g] + 1;
        end
        clk_d = pins.cnt_clk;
        ld_d = pins.load_n;
      end
    end
  end

  sudc_pins_sva #(.DECIMAL(1'b1)) u_sudc_pins_sva (.clock(clock), .rst(rst),
    .cnt_clk(g_pair[1].pins.cnt_clk), .cnt_en_n(g_pair[1].pins.cnt_en_n),
    .cnt_down(g_pair[1].pins.cnt_down), .load_n(g_pair[1].pins.load_n),
    .preset(g_pair[1].pins.preset), .q(g_pair[1].pins.q),
    .max_min(g_pair[1].pins.max_min), .ripple_n(g_pair[1].pins.ripple_n));

  // system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // watchdog, far beyond eight short runs
  initial begin
    #500000;
    n_fail++;
    print_verdict();
  end

  // main sequence: loads at limits, runs both ways, interrupts
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    n_fail = 0;
    checks = 0;
    void'($urandom(21));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd_reg(sudc_pkg::DIV_OFS);
    check(got[0], 32'(sudc_pkg::DIV_RESET));
    rd_reg(8'h20);
    check(got[1], 32'h0);
    wr_reg(sudc_pkg::DIV_OFS, 32'h3);
    for (int i = 0; i < 8; i++) begin
      p = (i < 4) ? tbl[i] : 4'($urandom_range(15, 0));
      mask = 2'($urandom_range(3, 0));
      wr_reg(sudc_pkg::MASK_OFS, 32'(mask));
      wr_reg(sudc_pkg::PRESET_OFS, 32'(p));
      wr_reg(sudc_pkg::CTRL_OFS, 32'h4);
      k = 0;
      do begin
        rd_reg(sudc_pkg::STATUS_OFS);
        k++;
      end while (got[1][1] !== 1'b1 && k < 40);
      check(32'(got[1][1]), 32'h1);
      wr_reg(sudc_pkg::CTRL_OFS, 32'(i % 2) * 2 + 1);
      repeat ($urandom_range(120, 20)) @(posedge clock);
      wr_reg(sudc_pkg::CTRL_OFS, 32'h0);
      repeat (12) @(posedge clock);
      rd_reg(sudc_pkg::COUNT_OFS);
      for (int g = 0; g < 2; g++) begin
        check(got[g], 32'(exp_q[g]) | (32'h1 << sudc_pkg::CNT_RIPPLE_BIT));
      end
      rd_reg(sudc_pkg::STATUS_OFS);
      for (int g = 0; g < 2; g++) begin
        check(got[g], 32'(exp_st[g]));
        check(32'(irq[g]), 32'(|(exp_st[g] & mask)));
      end
      wr_reg(sudc_pkg::STATUS_OFS, 32'h3);
      rd_reg(sudc_pkg::STATUS_OFS);
      check(got[0] | got[1], 32'h0);
    end
    print_verdict();
  end
endmodule : sync_updown_counter_bcd_bin_test
